/* rtl/srp_status_bank.sv */
// Status readout page bank with AXI4-Lite register access and event interrupt
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none

module srp_status_bank import srp_pkg::*; #(
	parameter int unsigned AW = ADDR_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [AW-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Front-end status
	input wire srp_fe_status_t fe_status,
	input wire logic rx_start,
	input wire srp_levels_t levels,
	input wire srp_timing_t timing,
	input wire srp_limiter_t limiter,
	// Front-end events
	input wire logic store_strength_cmd,
	input wire logic thresh_cross,
	input wire logic proto_err,
	// Page selections to the other views
	output logic [1:0] adc_view_page_sel,
	output logic [1:0] cal_view_page_sel,
	output logic [3:0] strength_view_type_sel,
	// Effective limiter attenuation
	output srp_limiter_t limiter_atten,
	// Interrupt
	output logic irq
);

	logic [7:0] page_reg;
	logic decode_src_reg;
	logic pll_prev_reg;
	logic [EV_W-1:0] irq_status_reg;
	logic [EV_W-1:0] irq_status_next;
	logic [EV_W-1:0] irq_enable_reg;
	logic [EV_W-1:0] irq_clear;
	logic [EV_W-1:0] events;
	logic [AW-1:0] wr_addr_reg;
	logic [31:0] wr_data_reg;
	logic [3:0] wr_strb_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic do_write;
	logic wr_hit;
	logic ar_take;
	logic [7:0] strength_view;
	logic [7:0] limiter_view;
	logic [7:0] gain_lock_view;
	logic [31:0] rd_value;
	logic rd_hit;

	// Page fields straight from the select register
	assign adc_view_page_sel = page_reg[ADC_PAGE_LSB +: 2];
	assign cal_view_page_sel = page_reg[CAL_PAGE_LSB +: 2];
	assign strength_view_type_sel = page_reg[TYPE_LSB +: 4];

	srp_strength_view u_strength_view (
		.aclk(aclk),
		.aresetn(aresetn),
		.levels(levels),
		.timing(timing),
		.store_strength_cmd(store_strength_cmd),
		.type_sel(page_reg[TYPE_LSB +: 4]),
		.view(strength_view)
	);

	// ---- Write channel ----

	assign do_write = aw_held_reg && w_held_reg && !bvalid;
	assign wr_hit = wr_addr_reg == ADDR_PAGE_SEL || wr_addr_reg == ADDR_IRQ_ENABLE ||
		wr_addr_reg == ADDR_IRQ_CLEAR;

	// Address and data taken in either order, held until the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_held_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_held_reg <= 1'b1;
			wr_addr_reg <= awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			w_held_reg <= 1'b0;
			wr_data_reg <= '0;
			wr_strb_reg <= '0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_held_reg <= 1'b1;
			wr_data_reg <= wdata;
			wr_strb_reg <= wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Page select only changes on a write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_reg <= PAGE_SEL_RESET;
		end else if (do_write && wr_addr_reg == ADDR_PAGE_SEL && wr_strb_reg[0]) begin
			page_reg <= wr_data_reg[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_reg <= IRQ_ENABLE_RESET;
		end else if (do_write && wr_addr_reg == ADDR_IRQ_ENABLE && wr_strb_reg[0]) begin
			irq_enable_reg <= wr_data_reg[EV_W-1:0];
		end
	end

	// ---- Front-end state ----

	// Decode source held from reception start to the next one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			decode_src_reg <= 1'b0;
		end else if (rx_start) begin
			decode_src_reg <= fe_status.decode_q;
		end
	end

	// Codes above the top step give no attenuation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			limiter_atten <= '0;
		end else begin
			limiter_atten.q <= (limiter.q > LIMITER_MAX_STEP) ? 3'h0 : limiter.q;
			limiter_atten.i <= (limiter.i > LIMITER_MAX_STEP) ? 3'h0 : limiter.i;
		end
	end

	// ---- Events and interrupt ----

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_prev_reg <= 1'b0;
		end else begin
			pll_prev_reg <= fe_status.pll_locked;
		end
	end

	always_comb begin
		events = '0;
		events[EV_NOISE_STORED] = store_strength_cmd;
		events[EV_THRESH_CROSS] = thresh_cross;
		events[EV_PROTO_ERR] = proto_err;
		events[EV_PLL_UNLOCK] = pll_prev_reg && !fe_status.pll_locked;
	end

	assign irq_clear = (do_write && wr_addr_reg == ADDR_IRQ_CLEAR && wr_strb_reg[0]) ?
		wr_data_reg[EV_W-1:0] : '0;
	// A new event wins over a clear in the same cycle
	assign irq_status_next = (irq_status_reg & ~irq_clear) | events;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_reg & irq_enable_reg);
		end
	end

	// ---- Read channel ----

	// Gain and lock status in its documented bit order
	always_comb begin
		gain_lock_view = fe_status;
		gain_lock_view[3] = decode_src_reg;
	end

	// Page 00 of 2Ch; other pages belong to other blocks
	always_comb begin
		limiter_view = 8'h00;
		if (page_reg[CAL_PAGE_LSB +: 2] == CAL_PAGE_LIMITER) begin
			limiter_view[5:3] = limiter.q;
			limiter_view[2:0] = limiter.i;
		end
	end

	// Pure decode; a read changes no state
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit = 1'b1;
		case (araddr)
			ADDR_PAGE_SEL: rd_value[7:0] = page_reg;
			ADDR_GAIN_LOCK: rd_value[7:0] = gain_lock_view;
			ADDR_STRENGTH: rd_value[7:0] = strength_view;
			ADDR_LIMITER: rd_value[7:0] = limiter_view;
			ADDR_IRQ_STATUS: rd_value[EV_W-1:0] = irq_status_reg;
			ADDR_IRQ_ENABLE: rd_value[EV_W-1:0] = irq_enable_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	assign ar_take = arvalid && arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_value;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ---- Checks ----

	property p_page_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_addr_reg == ADDR_PAGE_SEL && wr_strb_reg[0])
		|=> strength_view_type_sel == $past(wr_data_reg[3:0]) && adc_view_page_sel == $past(wr_data_reg[7:6]);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page select not written");

	property p_cal_page;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_addr_reg == ADDR_PAGE_SEL && wr_strb_reg[0])
		|=> cal_view_page_sel == $past(wr_data_reg[5:4]);
	endproperty
	a_cal_page: assert property (p_cal_page) else $error("2Ch page field wrong");

	property p_phase_bit;
		@(posedge aclk) disable iff (!aresetn)
		(ar_take && araddr == ADDR_GAIN_LOCK)
		|=> rvalid && rdata[7] == $past(fe_status.subc_in_phase) && rdata[6:4] == $past(fe_status.agc_level);
	endproperty
	a_phase_bit: assert property (p_phase_bit) else $error("phase or AGC bits wrong");

	property p_lock_bits;
		@(posedge aclk) disable iff (!aresetn)
		(ar_take && araddr == ADDR_GAIN_LOCK)
		|=> rdata[2:0] == $past({fe_status.carrier_stable_flag, fe_status.pll_locked, fe_status.osc_stable});
	endproperty
	a_lock_bits: assert property (p_lock_bits) else $error("stable or lock bits wrong");

	property p_decode_hold;
		@(posedge aclk) disable iff (!aresetn)
		!rx_start |=> $stable(decode_src_reg);
	endproperty
	a_decode_hold: assert property (p_decode_hold) else $error("decode source moved");

	property p_limiter_zero;
		@(posedge aclk) disable iff (!aresetn)
		(ar_take && araddr == ADDR_LIMITER && cal_view_page_sel == CAL_PAGE_LIMITER)
		|=> rdata[7:6] == 2'h0 && rdata[5:3] == $past(limiter.q) && rdata[2:0] == $past(limiter.i);
	endproperty
	a_limiter_zero: assert property (p_limiter_zero) else $error("limiter view wrong");

	property p_no_atten;
		@(posedge aclk) disable iff (!aresetn)
		limiter.q > LIMITER_MAX_STEP |=> limiter_atten.q == 3'h0;
	endproperty
	a_no_atten: assert property (p_no_atten) else $error("limiter code above 4 attenuates");

	property p_read_quiet;
		@(posedge aclk) disable iff (!aresetn)
		(ar_take && !do_write) |=> $stable(page_reg) && $stable(irq_enable_reg);
	endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("read changed state");

	property p_strength_read;
		@(posedge aclk) disable iff (!aresetn)
		(ar_take && araddr == ADDR_STRENGTH && strength_view_type_sel == TYPE_LIVE)
		|=> rdata[7:0] == $past({levels.live.q, levels.live.i});
	endproperty
	a_strength_read: assert property (p_strength_read) else $error("live strength read wrong");

	property p_irq_level;
		@(posedge aclk) disable iff (!aresetn)
		|(irq_status_reg & irq_enable_reg) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("enabled event did not raise irq");

	property p_event_wins;
		@(posedge aclk) disable iff (!aresetn)
		proto_err |=> irq_status_reg[EV_PROTO_ERR];
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("event lost against clear");

endmodule : srp_status_bank

`default_nettype wire

/* rtl/srp_pkg.sv */
// Package: register map, field layout, codes and carrier types of the status readout bank
`default_nettype none

package srp_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PAGE_SEL = 8'h29;
	localparam logic [7:0] IDX_GAIN_LOCK = 8'h2a;
	localparam logic [7:0] IDX_STRENGTH = 8'h2b;
	localparam logic [7:0] IDX_LIMITER = 8'h2c;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h31;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h32;

	localparam int unsigned ADDR_W = 10;
	localparam logic [9:0] ADDR_PAGE_SEL = {IDX_PAGE_SEL, 2'h0};
	localparam logic [9:0] ADDR_GAIN_LOCK = {IDX_GAIN_LOCK, 2'h0};
	localparam logic [9:0] ADDR_STRENGTH = {IDX_STRENGTH, 2'h0};
	localparam logic [9:0] ADDR_LIMITER = {IDX_LIMITER, 2'h0};
	localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [9:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'h0};
	localparam logic [9:0] ADDR_IRQ_CLEAR = {IDX_IRQ_CLEAR, 2'h0};

	// Page select fields and reset value
	localparam int unsigned ADC_PAGE_LSB = 6;
	localparam int unsigned CAL_PAGE_LSB = 4;
	localparam int unsigned TYPE_LSB = 0;
	localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
	localparam logic [1:0] CAL_PAGE_LIMITER = 2'h0;

	// Signal-strength view type codes
	localparam logic [3:0] TYPE_LIVE = 4'h0;
	localparam logic [3:0] TYPE_NOISE = 4'h2;
	localparam logic [3:0] TYPE_PILOT = 4'h4;
	localparam logic [3:0] TYPE_SECOND_BYTE = 4'h6;
	localparam logic [3:0] TYPE_PEAK = 4'h8;
	localparam logic [3:0] TYPE_CROSS_TIME = 4'hc;
	localparam logic [3:0] TYPE_OVER_DURATION = 4'hd;
	localparam logic [3:0] TYPE_ERR_TIME = 4'he;

	// Highest gain limiter step that attenuates
	localparam logic [2:0] LIMITER_MAX_STEP = 3'h4;

	// Interrupt event bits
	localparam int unsigned EV_W = 4;
	localparam int unsigned EV_NOISE_STORED = 0;
	localparam int unsigned EV_THRESH_CROSS = 1;
	localparam int unsigned EV_PROTO_ERR = 2;
	localparam int unsigned EV_PLL_UNLOCK = 3;
	localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0] q;
		logic [3:0] i;
	} srp_strength_t;

	typedef struct packed {
		srp_strength_t live;
		srp_strength_t pilot;
		srp_strength_t second_byte;
		srp_strength_t peak;
	} srp_levels_t;

	typedef struct packed {
		logic [7:0] cross_time;
		logic [7:0] over_duration;
		logic [7:0] err_time;
	} srp_timing_t;

	// Same bit order as the gain and lock status register
	typedef struct packed {
		logic subc_in_phase;
		logic [2:0] agc_level;
		logic decode_q;
		logic carrier_stable_flag;
		logic pll_locked;
		logic osc_stable;
	} srp_fe_status_t;

	typedef struct packed {
		logic [2:0] q;
		logic [2:0] i;
	} srp_limiter_t;

endpackage : srp_pkg

`default_nettype wire

/* rtl/srp_strength_view.sv */
// Signal-strength view selector with the captured noise level
`default_nettype none

module srp_strength_view import srp_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Front-end measurements
	input wire srp_levels_t levels,
	input wire srp_timing_t timing,
	input wire logic store_strength_cmd,
	// View selection and result
	input wire logic [3:0] type_sel,
	output logic [7:0] view
);

	srp_strength_t noise_reg;

	// Noise level only moves on the store command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			noise_reg <= '0;
		end else if (store_strength_cmd) begin
			noise_reg <= levels.live;
		end
	end

	// Q in upper nibble, I in lower for the level views; timing views are whole bytes
	always_comb begin
		case (type_sel)
			TYPE_LIVE: view = levels.live;
			TYPE_NOISE: view = noise_reg;
			TYPE_PILOT: view = levels.pilot;
			TYPE_SECOND_BYTE: view = levels.second_byte;
			TYPE_PEAK: view = levels.peak;
			TYPE_CROSS_TIME: view = timing.cross_time;
			TYPE_OVER_DURATION: view = timing.over_duration;
			TYPE_ERR_TIME: view = timing.err_time;
			default: view = 8'h00;
		endcase
	end

	property p_noise_capture;
		@(posedge aclk) disable iff (!aresetn)
		store_strength_cmd ##1 (type_sel == TYPE_NOISE) |-> view == $past(levels.live);
	endproperty
	a_noise_capture: assert property (p_noise_capture) else $error("noise view not captured");

	property p_noise_hold;
		@(posedge aclk) disable iff (!aresetn)
		!store_strength_cmd |=> $stable(noise_reg);
	endproperty
	a_noise_hold: assert property (p_noise_hold) else $error("noise level moved without store");

	property p_peak_nibbles;
		@(posedge aclk) disable iff (!aresetn)
		type_sel == TYPE_PEAK |-> view[7:4] == levels.peak.q && view[3:0] == levels.peak.i;
	endproperty
	a_peak_nibbles: assert property (p_peak_nibbles) else $error("peak nibbles misplaced");

	property p_unused_code;
		@(posedge aclk) disable iff (!aresetn)
		(type_sel inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hf}) |-> view == 8'h00;
	endproperty
	a_unused_code: assert property (p_unused_code) else $error("unused type code not zero");

endmodule : srp_strength_view

`default_nettype wire

/* test/srp_status_bank_bench.sv */
// Self-checking bench of the status readout page bank
`default_nettype none

module srp_status_bank_bench import srp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [9:0] awaddr = 10'h0, araddr = 10'h0;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	srp_fe_status_t fe_status = 8'hd7;
	srp_levels_t levels = 32'h3c5a71e2;
	srp_timing_t timing = 24'h172839;
	srp_limiter_t limiter = 6'h0;
	logic rx_start = 1'b0, store_strength_cmd = 1'b0, thresh_cross = 1'b0, proto_err = 1'b0;
	logic [1:0] adc_view_page_sel, cal_view_page_sel;
	logic [3:0] strength_view_type_sel;
	srp_limiter_t limiter_atten;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [1:0] resp;
	logic [11:0] rows [16];

	always #12.5 aclk = ~aclk;

	srp_status_bank u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.fe_status(fe_status), .rx_start(rx_start), .levels(levels), .timing(timing), .limiter(limiter),
		.store_strength_cmd(store_strength_cmd), .thresh_cross(thresh_cross), .proto_err(proto_err),
		.adc_view_page_sel(adc_view_page_sel), .cal_view_page_sel(cal_view_page_sel),
		.strength_view_type_sel(strength_view_type_sel), .limiter_atten(limiter_atten), .irq(irq)
	);

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk

	// Write address and data offered together, each released when taken
	task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		// Gap edge so the next call never reassigns ready in this step
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		// Gap edge so the next call never reassigns ready in this step
		@(posedge aclk);
	endtask : axi_rd

	task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp, input logic [1:0] er);
		axi_rd(a, rd, resp);
		chk(what, exp, rd);
		chk({what, " resp"}, {30'h0, er}, {30'h0, resp});
	endtask : rd_chk

	task automatic wr_chk(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
		axi_wr(a, d, resp);
		chk("write resp", {30'h0, er}, {30'h0, resp});
	endtask : wr_chk

	// One-cycle strobe; bits are store, reception start, threshold, protocol error
	task automatic pulse(input logic [3:0] which);
		{store_strength_cmd, rx_start, thresh_cross, proto_err} <= which;
		@(posedge aclk);
		{store_strength_cmd, rx_start, thresh_cross, proto_err} <= 4'h0;
		repeat (3) @(posedge aclk);
	endtask : pulse

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		// Type code beside the expected view, noise level not yet stored
		rows = '{{4'h0, 8'h3c}, {4'h1, 8'h00}, {4'h2, 8'h00}, {4'h3, 8'h00}, {4'h4, 8'h5a}, {4'h5, 8'h00},
			{4'h6, 8'h71}, {4'h7, 8'h00}, {4'h8, 8'he2}, {4'h9, 8'h00}, {4'ha, 8'h00}, {4'hb, 8'h00},
			{4'hc, 8'h17}, {4'hd, 8'h28}, {4'he, 8'h39}, {4'hf, 8'h00}};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk("page reset", ADDR_PAGE_SEL, 32'h0, RESP_OKAY);
		chk("irq reset", 32'h0, {31'h0, irq});
		for (int n = 0; n < 16; n++) begin
			wr_chk(ADDR_PAGE_SEL, {24'h0, 4'h0, rows[n][11:8]}, RESP_OKAY);
			rd_chk("strength view", ADDR_STRENGTH, {24'h0, rows[n][7:0]}, RESP_OKAY);
			chk("type out", {28'h0, rows[n][11:8]}, {28'h0, strength_view_type_sel});
		end
		// Noise level taken at the command, later changes of live ignored
		pulse(4'h8);
		levels.live <= 8'h96;
		wr_chk(ADDR_PAGE_SEL, {24'h0, TYPE_NOISE}, RESP_OKAY);
		rd_chk("noise view", ADDR_STRENGTH, 32'h3c, RESP_OKAY);
		rd_chk("noise again", ADDR_STRENGTH, 32'h3c, RESP_OKAY);
		// Decode source follows only the reception start
		rd_chk("status pre", ADDR_GAIN_LOCK, 32'hd7, RESP_OKAY);
		fe_status.decode_q <= 1'b1;
		fe_status.agc_level <= 3'h2;
		@(posedge aclk);
		rd_chk("status held", ADDR_GAIN_LOCK, 32'ha7, RESP_OKAY);
		pulse(4'h4);
		fe_status.decode_q <= 1'b0;
		fe_status.subc_in_phase <= 1'b0;
		fe_status.carrier_stable_flag <= 1'b0;
		@(posedge aclk);
		rd_chk("status latched", ADDR_GAIN_LOCK, 32'h2b, RESP_OKAY);
		// Limiter view and effective attenuation
		limiter <= {3'h6, 3'h3};
		repeat (3) @(posedge aclk);
		chk("atten q6 i3", 32'h03, {26'h0, limiter_atten});
		rd_chk("limiter page 0", ADDR_LIMITER, 32'h33, RESP_OKAY);
		limiter <= {3'h4, 3'h7};
		repeat (3) @(posedge aclk);
		chk("atten q4 i7", 32'h20, {26'h0, limiter_atten});
		rd_chk("limiter q4 i7", ADDR_LIMITER, 32'h27, RESP_OKAY);
		wr_chk(ADDR_PAGE_SEL, 32'hd0, RESP_OKAY);
		chk("adc page", 32'h3, {30'h0, adc_view_page_sel});
		chk("cal page", 32'h1, {30'h0, cal_view_page_sel});
		rd_chk("page back", ADDR_PAGE_SEL, 32'hd0, RESP_OKAY);
		rd_chk("limiter page 1", ADDR_LIMITER, 32'h0, RESP_OKAY);
		// Refused accesses
		rd_chk("adc view unmapped", 10'hb4, 32'h0, RESP_SLVERR);
		rd_chk("clear read", ADDR_IRQ_CLEAR, 32'h0, RESP_SLVERR);
		wr_chk(ADDR_GAIN_LOCK, 32'hff, RESP_SLVERR);
		wr_chk(10'h3fc, 32'hff, RESP_SLVERR);
		rd_chk("page kept", ADDR_PAGE_SEL, 32'hd0, RESP_OKAY);
		// Interrupt: masked event, enabled event, clear
		wr_chk(ADDR_IRQ_ENABLE, 32'h2, RESP_OKAY);
		pulse(4'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		pulse(4'h2);
		chk("irq raised", 32'h1, {31'h0, irq});
		fe_status.pll_locked <= 1'b0;
		repeat (3) @(posedge aclk);
		rd_chk("irq status", ADDR_IRQ_STATUS, 32'hf, RESP_OKAY);
		rd_chk("irq enable", ADDR_IRQ_ENABLE, 32'h2, RESP_OKAY);
		wr_chk(ADDR_IRQ_CLEAR, 32'hf, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd_chk("status cleared", ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
		// Protocol error in the very cycle the clear lands; the event must win
		fork
			wr_chk(ADDR_IRQ_CLEAR, 32'h4, RESP_OKAY);
			begin
				@(posedge aclk);
				proto_err <= 1'b1;
				@(posedge aclk);
				proto_err <= 1'b0;
			end
		join
		rd_chk("event beats clear", ADDR_IRQ_STATUS, 32'h4, RESP_OKAY);
		chk("irq still masked", 32'h0, {31'h0, irq});
		// Second reset in mid-run
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("adc page reset", 32'h0, {30'h0, adc_view_page_sel});
		rd_chk("page re-reset", ADDR_PAGE_SEL, 32'h0, RESP_OKAY);
		conclude();
	end
endmodule : srp_status_bank_bench

`default_nettype wire
